// ---- logic/cms_defs.vh ----
`ifndef CMS_DEFS_VH
`define CMS_DEFS_VH
// Stack bank select register
`define CMS_BSEL_WIDTH     4
`define CMS_BSEL_MODE_BIT  3
`define CMS_BSEL_RESET     4'h8
// Stack bytes pushed per call
`define CMS_PUSH_LEGACY    2'h2
`define CMS_PUSH_EXTENDED  2'h3
// Machine cycles of call instructions
`define CMS_LONG_CYC_LEG   3'h3
`define CMS_SHORT_CYC_LEG  3'h2
`define CMS_EXTRA_CYC      3'h1
// Opcode classes presented by the fetch logic
`define CMS_OP_NONE        3'h0
`define CMS_OP_LONG_CALL   3'h1
`define CMS_OP_SHORT_CALL  3'h2
`define CMS_OP_EXT_BRANCH  3'h3
`define CMS_OP_EXT_CALL    3'h4
`define CMS_OP_RETURN      3'h5
`define CMS_OP_OTHER       3'h6
// Cycle figures for the extended-address instructions and for all other instructions
`define CMS_EXT_BR_CYC     3'h3
`define CMS_EXT_CALL_CYC   3'h3
`define CMS_OTHER_CYC      3'h1
`endif

// ---- logic/cms_mode_reg.v ----
`timescale 1ns/100ps
`include "cms_defs.vh"
// Stack bank select register, whole nibble written at once
module cms_mode_reg (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // Nibble write port
  input  wire       wr_en,
  input  wire [3:0] wr_data,
  // Register contents
  output reg  [3:0] bank_sel_q
);
  reg [3:0] bank_sel_d;

  // Next value: full nibble replaced on write
  always @* begin
    bank_sel_d = bank_sel_q;
    if (wr_en) begin
      bank_sel_d = wr_data;
    end
  end

  // Reset forces legacy mode bit
  always @(posedge clk_sys) begin
    if (rst) begin
      bank_sel_q <= `CMS_BSEL_RESET;
    end else begin
      bank_sel_q <= bank_sel_d;
    end
  end
endmodule // cms_mode_reg

// ---- logic/cms_call_mode_switch.v ----
`timescale 1ns/100ps
`include "cms_defs.vh"
module cms_call_mode_switch (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // Register access from memory operation instructions
  input  wire       bank_sel_wr,
  input  wire [3:0] bank_sel_wdata,
  input  wire       bank_sel_rd,
  output reg  [3:0] bank_sel_rdata_q,
  // Instruction class from fetch
  input  wire       op_valid,
  input  wire [2:0] op_class,
  // Decode results
  output reg        extended_mode_q,
  output reg        legacy_mode_q,
  output reg        dec_valid_q,
  output reg        illegal_op_q,
  output reg  [1:0] push_bytes_q,
  output reg  [2:0] op_cycles_q,
  output reg        save_high_pc_q
);
  // Timing overview
  // A register write is taken at a rising edge and the stored
  // nibble is visible from the next edge on.
  // An instruction class is taken at a rising edge together with
  // the mode that the register holds at that edge.
  // Every decode result other than the two mode outputs stands for exactly one cycle and drops
  // back to zero when no instruction class is presented.
  // The two mode outputs stand until the register changes and
  // lag the register by one cycle.
  // Hazard: an instruction presented in the same cycle as a write
  // still decodes under the old mode; the fetch logic must allow
  // one cycle between a mode write and a dependent call.
  // Read data stand for one cycle after a read strobe and are
  // zero otherwise, so an idle bus never shows stale contents.

  // Stored register contents
  wire [3:0] bank_sel_q;
  // Decode results before the output registers
  reg        illegal_d;
  reg  [1:0] push_d;
  reg  [2:0] cyc_d;
  reg        high_d;
  wire       ext_mode;

  // Mode register instance
  // Bits 2:0 are kept as written; only bit 3 steers the decoder
  cms_mode_reg u_reg (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .wr_en      (bank_sel_wr),
    .wr_data    (bank_sel_wdata),
    .bank_sel_q (bank_sel_q)
  );

  // Mode from bit 3 of the stored register, so a write in this cycle
  // steers instructions from the next cycle on, not one in this cycle
  // A set bit means legacy mode, a clear bit extended mode
  assign ext_mode = ~bank_sel_q[`CMS_BSEL_MODE_BIT];

  // Helper functions, each used by more than one decode branch
  // Extra cycle for calls in extended mode
  function [2:0] cms_cycles;
    input [2:0] base;
    input       ext;
    begin
      cms_cycles = ext ? base + `CMS_EXTRA_CYC : base;
    end
  endfunction

  // Push depth by mode
  function [1:0] cms_push;
    input ext;
    begin
      cms_push = ext ? `CMS_PUSH_EXTENDED : `CMS_PUSH_LEGACY;
    end
  endfunction

  // Instruction decode under current mode
  // Defaults give a one-cycle instruction that touches no stack
  always @* begin
    illegal_d = 1'b0;
    push_d    = 2'h0;
    cyc_d     = `CMS_OTHER_CYC;
    high_d    = 1'b0;
    case (op_class)

      // Long call: full return address on the stack
      `CMS_OP_LONG_CALL: begin
        push_d = cms_push(ext_mode);
        cyc_d  = cms_cycles(`CMS_LONG_CYC_LEG, ext_mode);
        high_d = ext_mode;
      end

      // Short call into the fixed entry area
      `CMS_OP_SHORT_CALL: begin
        push_d = cms_push(ext_mode);
        cyc_d  = cms_cycles(`CMS_SHORT_CYC_LEG, ext_mode);
        high_d = ext_mode;
      end

      // Extended-address branch, flagged in legacy mode
      `CMS_OP_EXT_BRANCH: begin
        illegal_d = ~ext_mode;
        cyc_d     = `CMS_EXT_BR_CYC;
      end

      // Extended-address call; nothing pushed when refused
      `CMS_OP_EXT_CALL: begin
        illegal_d = ~ext_mode;
        push_d    = ext_mode ? `CMS_PUSH_EXTENDED : 2'h0;
        cyc_d     = `CMS_EXT_CALL_CYC;
        high_d    = ext_mode;
      end

      // Return pops what the matching call pushed
      `CMS_OP_RETURN: begin
        push_d = cms_push(ext_mode);
        high_d = ext_mode;
      end

      // Any other class: defaults stand
      default: begin
        illegal_d = 1'b0;
      end
    endcase
  end

  // Read data, zero unless a read is strobed
  always @(posedge clk_sys) begin
    if (rst) begin
      bank_sel_rdata_q <= 4'h0;
    end else begin
      bank_sel_rdata_q <= bank_sel_rd ? bank_sel_q : 4'h0;
    end
  end

  // Extended mode flag
  always @(posedge clk_sys) begin
    if (rst) begin
      extended_mode_q <= 1'b0;
    end else begin
      extended_mode_q <= ext_mode;
    end
  end

  // Legacy mode flag, always the inverse
  always @(posedge clk_sys) begin
    if (rst) begin
      legacy_mode_q <= 1'b1;
    end else begin
      legacy_mode_q <= ~ext_mode;
    end
  end

  // Decode valid, one cycle behind the class
  always @(posedge clk_sys) begin
    if (rst) begin
      dec_valid_q <= 1'b0;
    end else begin
      dec_valid_q <= op_valid;
    end
  end

  // Illegal instruction pulse
  always @(posedge clk_sys) begin
    if (rst) begin
      illegal_op_q <= 1'b0;
    end else begin
      illegal_op_q <= op_valid & illegal_d;
    end
  end

  // Stack bytes pushed or popped
  always @(posedge clk_sys) begin
    if (rst) begin
      push_bytes_q <= 2'h0;
    end else begin
      push_bytes_q <= op_valid ? push_d : 2'h0;
    end
  end

  // Machine cycles of the instruction
  always @(posedge clk_sys) begin
    if (rst) begin
      op_cycles_q <= 3'h0;
    end else begin
      op_cycles_q <= op_valid ? cyc_d : 3'h0;
    end
  end

  // Third return byte saved or restored
  always @(posedge clk_sys) begin
    if (rst) begin
      save_high_pc_q <= 1'b0;
    end else begin
      save_high_pc_q <= op_valid & high_d;
    end
  end
endmodule // cms_call_mode_switch

// ---- verification/cms_monitor.sv ----
`timescale 1ns/100ps
module cms_monitor (
  // Clock and reset
  input logic       clk_sys,
  input logic       rst,
  // Register access
  input logic       bank_sel_wr,
  input logic [3:0] bank_sel_wdata,
  input logic       bank_sel_rd,
  input logic [3:0] bank_sel_rdata_q,
  // Instruction class
  input logic       op_valid,
  input logic [2:0] op_class,
  // Decode results
  input logic       extended_mode_q,
  input logic       legacy_mode_q,
  input logic       dec_valid_q,
  input logic       illegal_op_q,
  input logic [1:0] push_bytes_q,
  input logic [2:0] op_cycles_q,
  input logic       save_high_pc_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Mode, stack depth, legality, cycle counts, readback and third return byte
  AST_MODE_PAIR: assert property (legacy_mode_q != extended_mode_q)
    else $error("mode outputs equal");
  AST_PUSH: assert property ($past(op_valid && op_class == 3'h1) |-> push_bytes_q == (extended_mode_q ? 2'h3 : 2'h2))
    else $error("call push depth wrong");
  AST_EXT_OP: assert property (dec_valid_q && ($past(op_class) inside {3'h3, 3'h4}) |-> illegal_op_q == legacy_mode_q)
    else $error("extended op legality wrong");
  AST_LONG_CYC: assert property ($past(op_valid && op_class == 3'h1) |-> op_cycles_q == 3'h3 + extended_mode_q)
    else $error("long call cycles wrong");
  AST_SHORT_CYC: assert property ($past(op_valid && op_class == 3'h2) |-> op_cycles_q == 3'h2 + extended_mode_q)
    else $error("short call cycles wrong");
  AST_RESET_LEG: assert property ($fell(rst) |-> legacy_mode_q && !extended_mode_q)
    else $error("not legacy after reset");
  AST_WR_RD: assert property (bank_sel_wr ##1 !bank_sel_wr ##1 bank_sel_rd |=> bank_sel_rdata_q == $past(bank_sel_wdata, 3))
    else $error("readback differs from write");
  AST_HIGH: assert property ($past(op_valid && op_class == 3'h1) |-> save_high_pc_q == extended_mode_q)
    else $error("third return byte wrong");
  AST_FOLLOW: assert property (bank_sel_wr |-> ##2 extended_mode_q == !$past(bank_sel_wdata[3], 2))
    else $error("mode does not follow write");
endmodule // cms_monitor
bind cms_call_mode_switch cms_monitor u_mon (.*);

// ---- verification/cms_call_mode_switch_tb.sv ----
`timescale 1ns/100ps
module cms_call_mode_switch_tb;
  logic clk_sys, rst, bank_sel_wr, bank_sel_rd, op_valid, extended_mode_q, legacy_mode_q, dec_valid_q, illegal_op_q;
  logic save_high_pc_q;
  logic [3:0] bank_sel_wdata, bank_sel_rdata_q;
  logic [2:0] op_class, op_cycles_q;
  logic [1:0] push_bytes_q;
  int failures = 0;
  int compares = 0;
  cms_call_mode_switch DUT (.clk_sys(clk_sys), .rst(rst), .bank_sel_wr(bank_sel_wr), .bank_sel_wdata(bank_sel_wdata),
    .bank_sel_rd(bank_sel_rd), .bank_sel_rdata_q(bank_sel_rdata_q), .op_valid(op_valid), .op_class(op_class),
    .extended_mode_q(extended_mode_q),
    .legacy_mode_q(legacy_mode_q), .dec_valid_q(dec_valid_q), .illegal_op_q(illegal_op_q),
    .push_bytes_q(push_bytes_q), .op_cycles_q(op_cycles_q), .save_high_pc_q(save_high_pc_q));
  // 25 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Compare one value
  task chk(input string n, input logic [3:0] e, input logic [3:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // Nibble write, then readback
  task wr(input logic [3:0] d);
    @(negedge clk_sys) begin bank_sel_wr = 1'b1; bank_sel_wdata = d; end
    @(negedge clk_sys) bank_sel_wr = 1'b0;
  endtask
  task rd(input logic [3:0] e);
    @(negedge clk_sys) bank_sel_rd = 1'b1;
    @(negedge clk_sys) bank_sel_rd = 1'b0;
    chk("bank_sel_rdata_q", e, bank_sel_rdata_q);
    chk("extended_mode_q", {3'h0, ~e[3]}, {3'h0, extended_mode_q});
    chk("legacy_mode_q", {3'h0, e[3]}, {3'h0, legacy_mode_q});
  endtask
  // One decoded instruction
  task op(input logic [2:0] c, input logic [1:0] p, input logic [2:0] y, input logic il, input logic h);
    @(negedge clk_sys) begin op_valid = 1'b1; op_class = c; end
    @(negedge clk_sys) op_valid = 1'b0;
    chk("push_bytes_q", {2'h0, p}, {2'h0, push_bytes_q});
    chk("op_cycles_q", {1'b0, y}, {1'b0, op_cycles_q});
    chk("illegal_op_q", {3'h0, il}, {3'h0, illegal_op_q});
    chk("save_high_pc_q", {3'h0, h}, {3'h0, save_high_pc_q});
    chk("dec_valid_q", 4'h1, {3'h0, dec_valid_q});
  endtask
  // Verdict
  task tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst = 1'b1; bank_sel_wr = 1'b0; bank_sel_rd = 1'b0; bank_sel_wdata = 4'h0; op_valid = 1'b0; op_class = 3'h0;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    rd(4'h8);
    op(3'h1, 2'h2, 3'h3, 1'b0, 1'b0);
    op(3'h2, 2'h2, 3'h2, 1'b0, 1'b0);
    op(3'h3, 2'h0, 3'h3, 1'b1, 1'b0);
    op(3'h4, 2'h0, 3'h3, 1'b1, 1'b0);
    op(3'h5, 2'h2, 3'h1, 1'b0, 1'b0);
    op(3'h6, 2'h0, 3'h1, 1'b0, 1'b0);
    $display("test legacy done");
    wr(4'h1);
    rd(4'h1);
    op(3'h1, 2'h3, 3'h4, 1'b0, 1'b1);
    op(3'h2, 2'h3, 3'h3, 1'b0, 1'b1);
    op(3'h3, 2'h0, 3'h3, 1'b0, 1'b0);
    op(3'h4, 2'h3, 3'h3, 1'b0, 1'b1);
    op(3'h5, 2'h3, 3'h1, 1'b0, 1'b1);
    $display("test extended done");
    wr(4'h9);
    op(3'h1, 2'h2, 3'h3, 1'b0, 1'b0);
    rd(4'h9);
    $display("test switch back done");
    wr(4'h2);
    rd(4'h2);
    @(negedge clk_sys) rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    rd(4'h8);
    op(3'h1, 2'h2, 3'h3, 1'b0, 1'b0);
    $display("test second reset done");
    tally_and_finish;
  end
endmodule // cms_call_mode_switch_tb
